// >>> include/datapath_map.svh
// constants of the 16-bit slice datapath: field positions, codes, reset values
// assumes inclusion by bare name from the package and the design modules
`ifndef DATAPATH_MAP_SVH
`define DATAPATH_MAP_SVH

// ****************************************************************
// widths
// ****************************************************************
`define DP_WIDTH 16
`define DP_NIB 4
`define DP_SLICES 4
`define DP_RAM_WORDS 16
`define DP_MSB 15

// ****************************************************************
// microinstruction fields
// ****************************************************************
`define SRC_LO 0
`define SRC_HI 2
`define FN_LO 3
`define FN_HI 5
`define DST_LO 6
`define DST_HI 8

// ****************************************************************
// source codes, r operand first
// ****************************************************************
`define SRC_PORTA_QREG 3'h0
`define SRC_PORTA_PORTB 3'h1
`define SRC_ZERO_QREG 3'h2
`define SRC_ZERO_PORTB 3'h3
`define SRC_ZERO_PORTA 3'h4
`define SRC_DIRECT_PORTA 3'h5
`define SRC_DIRECT_QREG 3'h6
`define SRC_DIRECT_ZERO 3'h7

// ****************************************************************
// function codes
// ****************************************************************
`define FN_PLUS 3'h0
`define FN_S_MINUS_R 3'h1
`define FN_R_MINUS_S 3'h2
`define FN_OR 3'h3
`define FN_AND 3'h4
`define FN_NOR 3'h5
`define FN_XOR 3'h6
`define FN_XNOR 3'h7

// ****************************************************************
// destination codes
// ****************************************************************
`define DST_Q_LOAD 3'h0
`define DST_NONE 3'h1
`define DST_RAM_YA 3'h2
`define DST_RAM 3'h3
`define DST_RAM_DOWN_Q 3'h4
`define DST_RAM_DOWN 3'h5
`define DST_RAM_UP_Q 3'h6
`define DST_RAM_UP 3'h7

// ****************************************************************
// reset values
// ****************************************************************
`define WORD_ZERO 16'h0000
`define NIB_ZERO 4'h0

`endif

// >>> include/datapath_pkg.sv
// types of the 16-bit slice datapath
// assumes datapath_map.svh on the include path
`default_nettype none
`include "datapath_map.svh"

package datapath_pkg;
    typedef logic [`DP_WIDTH-1:0] word_t;
    typedef logic [`DP_NIB-1:0] nib_t;

    typedef enum logic [2:0] {
        src_porta_qreg = `SRC_PORTA_QREG,
        src_porta_portb = `SRC_PORTA_PORTB,
        src_zero_qreg = `SRC_ZERO_QREG,
        src_zero_portb = `SRC_ZERO_PORTB,
        src_zero_porta = `SRC_ZERO_PORTA,
        src_direct_porta = `SRC_DIRECT_PORTA,
        src_direct_qreg = `SRC_DIRECT_QREG,
        src_direct_zero = `SRC_DIRECT_ZERO
    } src_t;

    typedef enum logic [2:0] {
        plus_r_s = `FN_PLUS,
        minus_r_from_s = `FN_S_MINUS_R,
        minus_s_from_r = `FN_R_MINUS_S,
        or_operands = `FN_OR,
        and_operands = `FN_AND,
        nor_of_operands = `FN_NOR,
        xor_operands = `FN_XOR,
        xnor_operands = `FN_XNOR
    } fn_t;

    typedef enum logic [2:0] {
        dst_q_load = `DST_Q_LOAD,
        dst_none = `DST_NONE,
        dst_ram_ya = `DST_RAM_YA,
        dst_ram = `DST_RAM,
        dst_ram_down_q = `DST_RAM_DOWN_Q,
        dst_ram_down = `DST_RAM_DOWN,
        dst_ram_up_q = `DST_RAM_UP_Q,
        dst_ram_up = `DST_RAM_UP
    } dst_t;
endpackage : datapath_pkg

`default_nettype wire

// >>> include/slice_if.sv
// carrier between the datapath top and one 4-bit alu slice
// assumes datapath_pkg compiled first
`timescale 1ns/10ps
`default_nettype none

interface slice_if;
    datapath_pkg::nib_t r;
    datapath_pkg::nib_t s;
    datapath_pkg::fn_t fn;
    logic cin;
    datapath_pkg::nib_t f;
    logic g;
    logic p;
    logic ovf;
    modport slice (input r, input s, input fn, input cin, output f, output g, output p, output ovf);
    modport host (output r, output s, output fn, output cin, input f, input g, input p, input ovf);
endinterface : slice_if

`default_nettype wire

// >>> rtl/alu_slice4.sv
// one 4-bit alu slice: eight functions, group generate and propagate
// assumes carry-in is resolved outside by lookahead
`timescale 1ns/10ps
`default_nettype none
`include "datapath_map.svh"

module alu_slice4 (
    slice_if.slice sl
);
    function automatic datapath_pkg::nib_t logic_op(input datapath_pkg::fn_t fn,
                                                    input datapath_pkg::nib_t r,
                                                    input datapath_pkg::nib_t s);
        unique case (fn)
            datapath_pkg::or_operands: logic_op = r | s;
            datapath_pkg::and_operands: logic_op = r & s;
            datapath_pkg::nor_of_operands: logic_op = ~r & ~s;
            datapath_pkg::xor_operands: logic_op = r ^ s;
            datapath_pkg::xnor_operands: logic_op = ~(r ^ s);
            default: logic_op = `NIB_ZERO;
        endcase
    endfunction : logic_op

    // ****************************************************************
    // operand conditioning
    // ****************************************************************
    wire arith = (sl.fn == datapath_pkg::plus_r_s) || (sl.fn == datapath_pkg::minus_r_from_s)
                 || (sl.fn == datapath_pkg::minus_s_from_r);
    wire [3:0] x = (sl.fn == datapath_pkg::minus_r_from_s) ? ~sl.r : sl.r;
    wire [3:0] y = (sl.fn == datapath_pkg::minus_s_from_r) ? ~sl.s : sl.s;
    wire [4:0] gen_sum = {1'b0, x} + {1'b0, y};
    wire [4:0] full_sum = {1'b0, x} + {1'b0, y} + {4'h0, sl.cin};
    wire [3:0] low_sum = {1'b0, x[2:0]} + {1'b0, y[2:0]} + {3'h0, sl.cin};

    // ****************************************************************
    // results
    // ****************************************************************
    assign sl.f = arith ? full_sum[3:0] : logic_op(sl.fn, sl.r, sl.s);
    assign sl.g = arith & gen_sum[4];
    assign sl.p = arith & (&(x ^ y));
    assign sl.ovf = arith & (low_sum[3] ^ full_sum[4]);
endmodule : alu_slice4

`default_nettype wire

// >>> rtl/bitslice_alu_datapath16.sv
// 16-bit microprogrammed alu datapath of four 4-bit slices with register ram and q
// assumes microinstruction fields stable through the cycle; shift fills from linkage mux
`timescale 1ns/10ps
`default_nettype none
`include "datapath_map.svh"

module bitslice_alu_datapath16 (
    // clock, reset, enable
    input wire logic clk,
    input wire logic rst_b,
    input wire logic ce,
    // microinstruction
    input wire logic [8:0] instr,
    input wire logic [3:0] a_addr,
    input wire logic [3:0] b_addr,
    input wire logic carry_input,
    // direct data
    input wire logic direct_sel,
    input wire logic [15:0] imm_data,
    input wire logic [15:0] dbus_data,
    // shift linkage fills
    input wire logic ram_up_fill,
    input wire logic ram_down_fill,
    input wire logic q_up_fill,
    input wire logic q_down_fill,
    // result and status
    output logic [15:0] y_bus,
    output logic carry_output,
    output logic sign_bit,
    output logic zero_flag,
    output logic overflow_flag,
    // shift ends towards linkage
    output logic ram_msb_out,
    output logic ram_lsb_out,
    output logic q_msb_out,
    output logic q_lsb_out
);
    // ****************************************************************
    // functions
    // ****************************************************************
    function automatic datapath_pkg::word_t pick_r(input datapath_pkg::src_t src,
                                                   input datapath_pkg::word_t a,
                                                   input datapath_pkg::word_t d);
        unique case (src)
            datapath_pkg::src_porta_qreg, datapath_pkg::src_porta_portb: pick_r = a;
            datapath_pkg::src_direct_porta, datapath_pkg::src_direct_qreg,
            datapath_pkg::src_direct_zero: pick_r = d;
            default: pick_r = `WORD_ZERO;
        endcase
    endfunction : pick_r

    function automatic datapath_pkg::word_t pick_s(input datapath_pkg::src_t src,
                                                   input datapath_pkg::word_t a,
                                                   input datapath_pkg::word_t b,
                                                   input datapath_pkg::word_t q);
        unique case (src)
            datapath_pkg::src_porta_qreg, datapath_pkg::src_zero_qreg,
            datapath_pkg::src_direct_qreg: pick_s = q;
            datapath_pkg::src_porta_portb, datapath_pkg::src_zero_portb: pick_s = b;
            datapath_pkg::src_zero_porta, datapath_pkg::src_direct_porta: pick_s = a;
            default: pick_s = `WORD_ZERO;
        endcase
    endfunction : pick_s

    function automatic logic [4:0] lookahead(input logic [3:0] g, input logic [3:0] p, input logic cin);
        logic [4:0] c;
        c = {4'h0, cin};
        for (int k = 0; k < `DP_SLICES; k++) begin
            c[k+1] = g[k] | (p[k] & c[k]);
        end
        return c;
    endfunction : lookahead

    // ****************************************************************
    // storage
    // ****************************************************************
    datapath_pkg::word_t ram_r [0:`DP_RAM_WORDS-1];
    datapath_pkg::word_t q_r;

    // ****************************************************************
    // decode
    // ****************************************************************
    wire datapath_pkg::src_t src = datapath_pkg::src_t'(instr[`SRC_HI:`SRC_LO]);
    wire datapath_pkg::fn_t fn = datapath_pkg::fn_t'(instr[`FN_HI:`FN_LO]);
    wire datapath_pkg::dst_t dst = datapath_pkg::dst_t'(instr[`DST_HI:`DST_LO]);

    wire datapath_pkg::word_t port_a = ram_r[a_addr];
    wire datapath_pkg::word_t port_b = ram_r[b_addr];
    wire datapath_pkg::word_t d_word = direct_sel ? imm_data : dbus_data;
    wire datapath_pkg::word_t r_op = pick_r(src, port_a, d_word);
    wire datapath_pkg::word_t s_op = pick_s(src, port_a, port_b, q_r);

    // ****************************************************************
    // slices and lookahead carry
    // ****************************************************************
    logic [3:0] g_v;
    logic [3:0] p_v;
    logic [3:0] ovf_v;
    logic [4:0] c_v;
    datapath_pkg::word_t alu_f;

    assign c_v = lookahead(g_v, p_v, carry_input);

    for (genvar i = 0; i < `DP_SLICES; i++) begin : g_slice
        slice_if sif ();
        assign sif.r = r_op[i*`DP_NIB +: `DP_NIB];
        assign sif.s = s_op[i*`DP_NIB +: `DP_NIB];
        assign sif.fn = fn;
        assign sif.cin = c_v[i];
        assign alu_f[i*`DP_NIB +: `DP_NIB] = sif.f;
        assign g_v[i] = sif.g;
        assign p_v[i] = sif.p;
        assign ovf_v[i] = sif.ovf;
        alu_slice4 u_slice (
            .sl(sif.slice)
        );
    end

    // ****************************************************************
    // destination routing and shifters
    // ****************************************************************
    wire ram_we = (dst != datapath_pkg::dst_q_load) && (dst != datapath_pkg::dst_none);
    wire ram_down = (dst == datapath_pkg::dst_ram_down_q) || (dst == datapath_pkg::dst_ram_down);
    wire ram_up = (dst == datapath_pkg::dst_ram_up_q) || (dst == datapath_pkg::dst_ram_up);
    wire q_we = (dst == datapath_pkg::dst_q_load) || (dst == datapath_pkg::dst_ram_down_q)
                || (dst == datapath_pkg::dst_ram_up_q);

    wire datapath_pkg::word_t ram_in = ram_down ? {ram_down_fill, alu_f[`DP_MSB:1]} :
                                       ram_up ? {alu_f[`DP_MSB-1:0], ram_up_fill} : alu_f;
    wire datapath_pkg::word_t q_in = (dst == datapath_pkg::dst_ram_down_q) ?
                                     {q_down_fill, q_r[`DP_MSB:1]} :
                                     (dst == datapath_pkg::dst_ram_up_q) ?
                                     {q_r[`DP_MSB-1:0], q_up_fill} : alu_f;
    wire datapath_pkg::word_t y_nxt = (dst == datapath_pkg::dst_ram_ya) ? port_a : alu_f;
    wire zero_nxt = (alu_f == `WORD_ZERO);

    // ****************************************************************
    // register ram, written at b address only
    // ****************************************************************
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            for (int k = 0; k < `DP_RAM_WORDS; k++) begin
                ram_r[k] <= `WORD_ZERO;
            end
        end else if (ce && ram_we) begin
            ram_r[b_addr] <= ram_in;
        end
    end

    // ****************************************************************
    // q, result and status registers
    // ****************************************************************
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            q_r <= `WORD_ZERO;
            y_bus <= `WORD_ZERO;
            carry_output <= 1'b0;
            sign_bit <= 1'b0;
            zero_flag <= 1'b0;
            overflow_flag <= 1'b0;
        end else if (ce) begin
            if (q_we) begin
                q_r <= q_in;
            end
            y_bus <= y_nxt;
            carry_output <= c_v[`DP_SLICES];
            sign_bit <= alu_f[`DP_MSB];
            zero_flag <= zero_nxt;
            overflow_flag <= ovf_v[`DP_SLICES-1];
        end
    end

    // shift-end bits handed to the linkage mux
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            ram_msb_out <= 1'b0;
            ram_lsb_out <= 1'b0;
            q_msb_out <= 1'b0;
            q_lsb_out <= 1'b0;
        end else if (ce) begin
            ram_msb_out <= alu_f[`DP_MSB];
            ram_lsb_out <= alu_f[0];
            q_msb_out <= q_r[`DP_MSB];
            q_lsb_out <= q_r[0];
        end
    end

    // ****************************************************************
    // checks
    // ****************************************************************
    wire [16:0] add_chk = {1'b0, r_op} + {1'b0, s_op} + {16'h0000, carry_input};

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    sequence s_ram_write;
        ce && ram_we;
    endsequence

    sequence s_q_down;
        ce && (dst == datapath_pkg::dst_ram_down_q);
    endsequence

    property p_same_read;
        a_addr == b_addr |-> port_a == port_b;
    endproperty
    a_same_read: assert property (p_same_read) else $error("ports differ at equal address");

    property p_ram_store;
        logic [3:0] ad;
        datapath_pkg::word_t v;
        (s_ram_write, ad = b_addr, v = ram_in) |=> ram_r[ad] == v;
    endproperty
    a_ram_store: assert property (p_ram_store) else $error("ram word not stored at b address");

    property p_src_zero_q;
        src == datapath_pkg::src_zero_qreg |-> (r_op == `WORD_ZERO) && (s_op == q_r);
    endproperty
    a_src_zero_q: assert property (p_src_zero_q) else $error("zero,q source wrong");

    property p_src_d_zero;
        src == datapath_pkg::src_direct_zero |-> (r_op == d_word) && (s_op == `WORD_ZERO);
    endproperty
    a_src_d_zero: assert property (p_src_d_zero) else $error("d,zero source wrong");

    property p_add;
        fn == datapath_pkg::plus_r_s |-> alu_f == add_chk[15:0];
    endproperty
    a_add: assert property (p_add) else $error("add result wrong");

    property p_carry;
        ce && (fn == datapath_pkg::plus_r_s) |=> carry_output == $past(add_chk[16]);
    endproperty
    a_carry: assert property (p_carry) else $error("carry out wrong");

    property p_zero;
        ce |=> zero_flag == ($past(alu_f) == `WORD_ZERO);
    endproperty
    a_zero: assert property (p_zero) else $error("zero flag wrong");

    property p_q_down;
        datapath_pkg::word_t qv;
        logic fill;
        (s_q_down, qv = q_r, fill = q_down_fill) |=> q_r == {fill, qv[`DP_MSB:1]};
    endproperty
    a_q_down: assert property (p_q_down) else $error("q down shift wrong");

    property p_q_hold;
        ce && !q_we |=> $stable(q_r);
    endproperty
    a_q_hold: assert property (p_q_hold) else $error("q changed without load");

    property p_y_a;
        ce && (dst == datapath_pkg::dst_ram_ya) |=> y_bus == $past(port_a);
    endproperty
    a_y_a: assert property (p_y_a) else $error("y does not show port a");

    property p_freeze;
        !ce |=> $stable(y_bus) && $stable(q_r) && $stable(zero_flag);
    endproperty
    a_freeze: assert property (p_freeze) else $error("state moved while enable low");

    sequence s_q_up;
        ce && (dst == datapath_pkg::dst_ram_up_q);
    endsequence

    property p_q_up;
        datapath_pkg::word_t qv;
        logic fill;
        (s_q_up, qv = q_r, fill = q_up_fill) |=> q_r == {qv[`DP_MSB-1:0], fill};
    endproperty
    a_q_up: assert property (p_q_up) else $error("q up shift wrong");

    property p_q_load;
        datapath_pkg::word_t v;
        (ce && (dst == datapath_pkg::dst_q_load), v = alu_f) |=> q_r == v;
    endproperty
    a_q_load: assert property (p_q_load) else $error("q not loaded from alu");

    property p_sign;
        datapath_pkg::word_t v;
        (ce, v = alu_f) |=> sign_bit == v[`DP_MSB];
    endproperty
    a_sign: assert property (p_sign) else $error("sign bit wrong");

    property p_logic_flags;
        (ce && (fn != datapath_pkg::plus_r_s) && (fn != datapath_pkg::minus_r_from_s)
            && (fn != datapath_pkg::minus_s_from_r)) |=> !carry_output && !overflow_flag;
    endproperty
    a_logic_flags: assert property (p_logic_flags) else $error("carry or overflow on logic op");

    property p_ram_up;
        logic [3:0] ad;
        datapath_pkg::word_t v;
        logic fill;
        (ce && ram_up, ad = b_addr, v = alu_f, fill = ram_up_fill) |=> ram_r[ad] == {v[`DP_MSB-1:0], fill};
    endproperty
    a_ram_up: assert property (p_ram_up) else $error("ram up shift wrong");
endmodule : bitslice_alu_datapath16

`default_nettype wire

// >>> verif/microword_source.sv
// sequencer and pipeline register model feeding the datapath microword
// assumes the bench calls issue once per cycle; fields change at the falling edge
`timescale 1ns/10ps
`default_nettype none

module microword_source (
    // clock
    input wire logic clk,
    // microword toward the datapath
    output var logic ce,
    output var logic [8:0] instr,
    output var logic [3:0] a_addr,
    output var logic [3:0] b_addr,
    output var logic carry_input,
    output var logic direct_sel,
    output var logic [15:0] imm_data,
    output var logic [15:0] dbus_data,
    output var logic ram_up_fill,
    output var logic ram_down_fill,
    output var logic q_up_fill,
    output var logic q_down_fill
);
    initial begin
        {ce, instr, a_addr, b_addr, carry_input, direct_sel} = '0;
        {imm_data, dbus_data, ram_up_fill, ram_down_fill, q_up_fill, q_down_fill} = '0;
    end

    // ****************************************************************
    // one microword, held the whole following cycle
    // ****************************************************************
    task automatic issue(input logic en, input logic [8:0] iw, input logic [3:0] aa, input logic [3:0] ba,
                         input logic cin, input logic dsel, input logic [15:0] imm, input logic [15:0] dbus,
                         input logic [3:0] fl);
        @(negedge clk);
        ce = en;
        instr = iw;
        a_addr = aa;
        b_addr = ba;
        carry_input = cin;
        direct_sel = dsel;
        imm_data = imm;
        dbus_data = dbus;
        {ram_up_fill, ram_down_fill, q_up_fill, q_down_fill} = fl;
    endtask : issue
endmodule : microword_source

`default_nettype wire

// >>> verif/test_bitslice_alu_datapath16.sv
// self-checking bench of the 16-bit slice datapath with a shadow ram and q model
// assumes datapath_pkg and microword_source compiled first
`timescale 1ns/10ps
`default_nettype none

module test_bitslice_alu_datapath16;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic ce, carry_input, direct_sel, ram_up_fill, ram_down_fill, q_up_fill, q_down_fill;
    logic [8:0] instr;
    logic [3:0] a_addr, b_addr;
    logic [15:0] imm_data, dbus_data, y_bus;
    logic carry_output, sign_bit, zero_flag, overflow_flag, ram_msb_out, ram_lsb_out, q_msb_out, q_lsb_out;
    int seed = 30;
    int n_mismatch = 0;
    int samples_checked = 0;
    datapath_pkg::word_t ram_m [16];
    datapath_pkg::word_t q_m, y_m;
    logic [7:0] fl_m;
    datapath_pkg::word_t corner [4] = '{16'hffff, 16'h7fff, 16'h8000, 16'h0000};

    always #12.5 clk = ~clk;

    microword_source useq (.clk(clk), .ce(ce), .instr(instr), .a_addr(a_addr), .b_addr(b_addr),
        .carry_input(carry_input), .direct_sel(direct_sel), .imm_data(imm_data), .dbus_data(dbus_data),
        .ram_up_fill(ram_up_fill), .ram_down_fill(ram_down_fill), .q_up_fill(q_up_fill),
        .q_down_fill(q_down_fill));

    bitslice_alu_datapath16 dut (.clk(clk), .rst_b(rst_b), .ce(ce), .instr(instr), .a_addr(a_addr),
        .b_addr(b_addr), .carry_input(carry_input), .direct_sel(direct_sel), .imm_data(imm_data),
        .dbus_data(dbus_data), .ram_up_fill(ram_up_fill), .ram_down_fill(ram_down_fill),
        .q_up_fill(q_up_fill), .q_down_fill(q_down_fill), .y_bus(y_bus), .carry_output(carry_output),
        .sign_bit(sign_bit), .zero_flag(zero_flag), .overflow_flag(overflow_flag),
        .ram_msb_out(ram_msb_out), .ram_lsb_out(ram_lsb_out), .q_msb_out(q_msb_out), .q_lsb_out(q_lsb_out));

    // ****************************************************************
    // reference of operand selection and alu
    // ****************************************************************
    function automatic logic [31:0] operands(input logic [2:0] src, input datapath_pkg::word_t a,
                                             input datapath_pkg::word_t b, input datapath_pkg::word_t q,
                                             input datapath_pkg::word_t d);
        case (src)
            3'h0: operands = {a, q};
            3'h1: operands = {a, b};
            3'h2: operands = {16'h0000, q};
            3'h3: operands = {16'h0000, b};
            3'h4: operands = {16'h0000, a};
            3'h5: operands = {d, a};
            3'h6: operands = {d, q};
            default: operands = {d, 16'h0000};
        endcase
    endfunction : operands

    // result {overflow, carry, f}
    function automatic logic [17:0] alu_ref(input datapath_pkg::word_t r, input datapath_pkg::word_t s,
                                            input logic [2:0] fn, input logic cin);
        logic [16:0] sum;
        datapath_pkg::word_t x, y;
        x = (fn == 3'h1) ? ~r : r;
        y = (fn == 3'h2) ? ~s : s;
        sum = {1'b0, x} + {1'b0, y} + {16'h0000, cin};
        case (fn)
            3'h0, 3'h1, 3'h2: alu_ref = {x[15] ^ y[15] ^ sum[15] ^ sum[16], sum};
            3'h3: alu_ref = {2'b00, r | s};
            3'h4: alu_ref = {2'b00, r & s};
            3'h5: alu_ref = {2'b00, ~r & ~s};
            3'h6: alu_ref = {2'b00, r ^ s};
            default: alu_ref = {2'b00, ~(r ^ s)};
        endcase
    endfunction : alu_ref

    task automatic check(input datapath_pkg::word_t got, input datapath_pkg::word_t exp);
        samples_checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    task automatic compare_all;
        check(y_bus, y_m);
        check(16'(carry_output), 16'(fl_m[7]));
        check(16'({sign_bit, overflow_flag}), 16'({fl_m[6], fl_m[4]}));
        check(16'(zero_flag), 16'(fl_m[5]));
        check(16'({ram_msb_out, ram_lsb_out, q_msb_out, q_lsb_out}), 16'(fl_m[3:0]));
    endtask : compare_all

    // ****************************************************************
    // one operation: drive, predict, compare after the edge
    // ****************************************************************
    task automatic op(input logic en, input logic [8:0] iw, input logic [3:0] aa, input logic [3:0] ba,
                      input logic cin, input logic dsel, input datapath_pkg::word_t imm,
                      input datapath_pkg::word_t dbus, input logic [3:0] fl);
        logic [31:0] rs;
        logic [17:0] res;
        datapath_pkg::word_t f;
        useq.issue(en, iw, aa, ba, cin, dsel, imm, dbus, fl);
        rs = operands(iw[2:0], ram_m[aa], ram_m[ba], q_m, dsel ? imm : dbus);
        res = alu_ref(rs[31:16], rs[15:0], iw[5:3], cin);
        f = res[15:0];
        if (en) begin
            y_m = (iw[8:6] == 3'h2) ? ram_m[aa] : f;
            fl_m = {res[16], f[15], f == 16'h0000, res[17], f[15], f[0], q_m[15], q_m[0]};
            case (iw[8:6])
                3'h0: q_m = f;
                3'h2, 3'h3: ram_m[ba] = f;
                3'h4: {ram_m[ba], q_m} = {fl[2], f[15:1], fl[0], q_m[15:1]};
                3'h5: ram_m[ba] = {fl[2], f[15:1]};
                3'h6: {ram_m[ba], q_m} = {f[14:0], fl[3], q_m[14:0], fl[1]};
                3'h7: ram_m[ba] = {f[14:0], fl[3]};
                default: ;
            endcase
        end
        @(posedge clk);
        #1;
        compare_all;
    endtask : op

    task automatic rand_op(input logic [8:0] iw);
        logic [31:0] r1, r2;
        r1 = $random(seed);
        r2 = $random(seed);
        op(r1[2:0] != 3'h0, iw, r1[7:4], r1[11:8], r1[12], r1[13], r2[15:0], r2[31:16], r1[19:16]);
    endtask : rand_op

    task automatic do_reset(input int n);
        useq.issue(1'b0, 9'h000, 4'h0, 4'h0, 1'b0, 1'b0, 16'h0000, 16'h0000, 4'h0);
        rst_b = 1'b0;
        repeat (n) @(negedge clk);
        rst_b = 1'b1;
        foreach (ram_m[k]) ram_m[k] = 16'h0000;
        q_m = 16'h0000;
        y_m = 16'h0000;
        fl_m = 8'h00;
        compare_all;
    endtask : do_reset

    task automatic results;
        $display("comparisons %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : results

    initial begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        results;
    end

    initial begin
        do_reset(11);
        // every register loaded from the direct input, both sources
        for (int i = 0; i < 17; i++) begin
            op(1'b1, {(i == 16) ? 3'h0 : 3'h3, 3'h3, 3'h7}, 4'h0, 4'(i), 1'b0, i[0], 16'h1234 + 16'(i),
               16'hbe00 + 16'(i), 4'h0);
        end
        // same word on both ports
        for (int i = 0; i < 32; i++) begin
            op(1'b1, {3'h1, i[4] ? 3'h6 : 3'h2, 3'h1}, 4'(i), 4'(i), 1'b1, 1'b0, 16'h0, 16'h0, 4'h0);
        end
        // carry, overflow and sign boundaries against a known one
        op(1'b1, {3'h3, 3'h3, 3'h7}, 4'h0, 4'h0, 1'b0, 1'b1, 16'h0001, 16'h0000, 4'h0);
        for (int k = 0; k < 12; k++) begin
            op(1'b1, {3'h1, 3'(k % 3), 3'h5}, 4'h0, 4'h1, k[0], 1'b0, 16'h0, corner[k / 3], 4'h0);
        end
        // every source, function and destination code, random data and enable
        for (int i = 0; i < 1024; i++) begin
            rand_op(9'(i));
        end
        do_reset(2);
        // ram and q cleared by the second reset
        for (int i = 0; i < 17; i++) begin
            op(1'b1, {3'h1, 3'h0, (i == 16) ? 3'h2 : 3'h4}, 4'(i), 4'h0, 1'b0, 1'b0, 16'h0, 16'h0, 4'h0);
        end
        results;
    end
endmodule : test_bitslice_alu_datapath16

`default_nettype wire
